/* File: gpc_consts.svh */
// register map, reset values and keys of one general purpose i/o port
// assumes byte addressing with one aligned 32-bit word per register
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH
`define GPC_ADDR_W       12
`define GPC_DATA_TOP     2'h0
`define GPC_OFF_DIR      12'h400
`define GPC_OFF_SENSE    12'h404
`define GPC_OFF_DUAL     12'h408
`define GPC_OFF_POL      12'h40C
`define GPC_OFF_MASK     12'h410
`define GPC_OFF_RAW      12'h414
`define GPC_OFF_MSTAT    12'h418
`define GPC_OFF_CLEAR    12'h41C
`define GPC_OFF_ALT      12'h420
`define GPC_OFF_DRV2     12'h500
`define GPC_OFF_DRV4     12'h504
`define GPC_OFF_DRV8     12'h508
`define GPC_OFF_ODRAIN   12'h50C
`define GPC_OFF_PUP      12'h510
`define GPC_OFF_PDN      12'h514
`define GPC_OFF_SLEW     12'h518
`define GPC_OFF_DIN      12'h51C
`define GPC_OFF_LOCK     12'h520
`define GPC_OFF_COMMIT   12'h524
`define GPC_OFF_ID_BASE  12'hFD0
`define GPC_ID_WORDS     12
`define GPC_UNLOCK_KEY   32'h5A5AA5A5
`define GPC_RST_ZERO     8'h00
`define GPC_RST_DRV2     8'hFF
`define GPC_RST_COMMIT   8'hFF
`define GPC_PORT_B       3'h1
`define GPC_PORT_C       3'h2
`define GPC_DBG_MASK_B   8'h80
`define GPC_DBG_MASK_C   8'h0F
`define GPC_TRIG_PIN     3'h4
`endif

/* File: gpc_pkg.sv */
// types shared by the port logic
// assumes gpc_consts.svh is on the include path
package gpc_pkg;
  typedef logic [7:0]  gpc_bits_t;
  typedef logic [31:0] gpc_word_t;
  typedef enum logic [1:0] {GPC_DRV_2MA, GPC_DRV_4MA, GPC_DRV_8MA}
    gpc_drive_t;
endpackage : gpc_pkg

/* File: gpc_port.sv */
// one general purpose i/o port: data, direction, interrupts, modes, pads
// assumes synchronous pad inputs and a one-cycle strobe register port
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`include "gpc_consts.svh"
`timescale 1ns/100ps
module gpc_port
  import gpc_pkg::*;
#(
  parameter int        WIDTH      = 8,
  parameter logic [2:0] PORT_INDEX = 3'h0,
  // identification values are arbitrary
  parameter logic [7:0] ID_BYTE0  = 8'h11,
  parameter logic [7:0] ID_BYTE1  = 8'h22,
  parameter logic [7:0] ID_BYTE2  = 8'h33,
  parameter logic [7:0] ID_BYTE3  = 8'h44
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic [`GPC_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  input  wire logic [WIDTH-1:0]       pad_in,
  output logic      [WIDTH-1:0]       pad_out,
  output logic      [WIDTH-1:0]       pad_oe,
  input  wire logic [WIDTH-1:0]       alt_out,
  input  wire logic [WIDTH-1:0]       alt_oe,
  output logic      [WIDTH-1:0]       alt_in,
  output logic      [WIDTH-1:0]       pull_up,
  output logic      [WIDTH-1:0]       pull_down,
  output logic      [WIDTH-1:0]       drive_2ma,
  output logic      [WIDTH-1:0]       drive_4ma,
  output logic      [WIDTH-1:0]       drive_8ma,
  output logic      [WIDTH-1:0]       slew_ctl,
  output logic      [WIDTH-1:0]       open_drain,
  output logic      [WIDTH-1:0]       input_en,
  output logic                        irq,
  output logic                        adc_trigger
);

  if (WIDTH != 8 || PORT_INDEX > 3'h6) begin : g_check
    $error("gpc_port: width must be 8 and port index 0 to 6");
  end

  gpc_bits_t pin_value_reg, pin_direction_reg;
  gpc_bits_t irq_sense_select, irq_dual_edge_select, irq_polarity_select;
  gpc_bits_t irq_mask_bits, edge_latch, alt_function_select;
  gpc_bits_t commit_permit_bits, digital_input_enable;
  gpc_bits_t pull_up_enable, pull_down_enable, open_drain_enable;
  gpc_bits_t drive_low_select, drive_mid_select, drive_high_select;
  gpc_bits_t slew_select, pin_sync, pin_prev;
  logic      unlocked, trig_prev;
  gpc_word_t id_word [`GPC_ID_WORDS];

  // debug pins differ per port
  wire gpc_bits_t dbg_mask =
    (PORT_INDEX == `GPC_PORT_B) ? `GPC_DBG_MASK_B :
    (PORT_INDEX == `GPC_PORT_C) ? `GPC_DBG_MASK_C : `GPC_RST_ZERO;

  // address decode
  wire logic      data_hit = addr[11:10] == `GPC_DATA_TOP;
  wire gpc_bits_t addr_mask = addr[9:2];
  wire logic      dir_hit  = addr == `GPC_OFF_DIR;
  wire logic      sns_hit  = addr == `GPC_OFF_SENSE;
  wire logic      dual_hit = addr == `GPC_OFF_DUAL;
  wire logic      pol_hit  = addr == `GPC_OFF_POL;
  wire logic      msk_hit  = addr == `GPC_OFF_MASK;
  wire logic      clr_hit  = addr == `GPC_OFF_CLEAR;
  wire logic      alt_hit  = addr == `GPC_OFF_ALT;
  wire logic      d2_hit   = addr == `GPC_OFF_DRV2;
  wire logic      d4_hit   = addr == `GPC_OFF_DRV4;
  wire logic      d8_hit   = addr == `GPC_OFF_DRV8;
  wire logic      od_hit   = addr == `GPC_OFF_ODRAIN;
  wire logic      pu_hit   = addr == `GPC_OFF_PUP;
  wire logic      pd_hit   = addr == `GPC_OFF_PDN;
  wire logic      slr_hit  = addr == `GPC_OFF_SLEW;
  wire logic      den_hit  = addr == `GPC_OFF_DIN;
  wire logic      lock_hit = addr == `GPC_OFF_LOCK;
  wire logic      cr_hit   = addr == `GPC_OFF_COMMIT;
  wire logic      id_hit   = addr >= `GPC_OFF_ID_BASE && addr[1:0] == 2'h0;
  wire logic [3:0] id_idx  = 4'(addr[5:2] - 4'h4);
  wire gpc_bits_t wbyte    = wdata[7:0];

  // commit guard for protected alt select bits
  wire gpc_bits_t commit_ok =
    ~dbg_mask | (unlocked ? commit_permit_bits : `GPC_RST_ZERO);
  wire gpc_bits_t next_alt =
    (wbyte & commit_ok) | (alt_function_select & ~commit_ok);

  // interrupt detection per pin
  gpc_bits_t edge_hit, irq_raw_state;
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    wire logic rise = pin_sync[i] & ~pin_prev[i];
    wire logic fall = ~pin_sync[i] & pin_prev[i];
    // edge choice and level choice
    assign edge_hit[i] = irq_dual_edge_select[i] ? (rise | fall) :
                         irq_polarity_select[i] ? rise : fall;
    assign irq_raw_state[i] = irq_sense_select[i] ?
      (pin_sync[i] == irq_polarity_select[i]) : edge_latch[i];
    // data bit: input capture or masked write
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        pin_value_reg[i] <= 1'b0;
      end else if (!pin_direction_reg[i]) begin
        pin_value_reg[i] <= pin_sync[i];
      end else if (wr && data_hit && addr_mask[i]) begin
        pin_value_reg[i] <= wdata[i];
      end
    end
  end

  wire gpc_bits_t clear_bits = (wr && clr_hit) ? wbyte : `GPC_RST_ZERO;
  // set wins over clear; edge held until cleared
  wire gpc_bits_t next_edge =
    (edge_latch & ~clear_bits) | (edge_hit & ~irq_sense_select);
  wire gpc_bits_t irq_masked_state = irq_raw_state & irq_mask_bits;
  wire logic trig_now = PORT_INDEX == `GPC_PORT_B &&
                        irq_masked_state[`GPC_TRIG_PIN];

  // drive selects are exclusive per pin
  wire gpc_bits_t drv_clear = (wr && (d2_hit || d4_hit || d8_hit)) ?
                              wbyte : `GPC_RST_ZERO;

  // read mux
  wire gpc_bits_t data_view = pin_value_reg & addr_mask;
  wire gpc_bits_t reg_view =
    data_hit ? data_view :
    dir_hit  ? pin_direction_reg :
    sns_hit  ? irq_sense_select :
    dual_hit ? irq_dual_edge_select :
    pol_hit  ? irq_polarity_select :
    msk_hit  ? irq_mask_bits :
    addr == `GPC_OFF_RAW   ? irq_raw_state :
    addr == `GPC_OFF_MSTAT ? irq_masked_state :
    alt_hit  ? alt_function_select :
    d2_hit   ? drive_low_select :
    d4_hit   ? drive_mid_select :
    d8_hit   ? drive_high_select :
    od_hit   ? open_drain_enable :
    pu_hit   ? pull_up_enable :
    pd_hit   ? pull_down_enable :
    slr_hit  ? slew_select :
    den_hit  ? digital_input_enable :
    lock_hit ? {7'h00, ~unlocked} :
    cr_hit   ? commit_permit_bits : `GPC_RST_ZERO;
  wire gpc_word_t next_rdata =
    !rd ? 32'h00000000 :
    id_hit ? id_word[id_idx] : {24'h000000, reg_view};

  // identification words, fixed
  for (genvar k = 0; k < `GPC_ID_WORDS; k++) begin : g_id
    assign id_word[k] = (k % 4 == 0) ? {24'h000000, ID_BYTE0} :
                        (k % 4 == 1) ? {24'h000000, ID_BYTE1} :
                        (k % 4 == 2) ? {24'h000000, ID_BYTE2} :
                                       {24'h000000, ID_BYTE3};
  end

  // control registers; reset restores defaults
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_direction_reg    <= `GPC_RST_ZERO;
      irq_sense_select     <= `GPC_RST_ZERO;
      irq_dual_edge_select <= `GPC_RST_ZERO;
      irq_polarity_select  <= `GPC_RST_ZERO;
      irq_mask_bits        <= `GPC_RST_ZERO;
      open_drain_enable    <= `GPC_RST_ZERO;
      pull_down_enable     <= `GPC_RST_ZERO;
      slew_select          <= `GPC_RST_ZERO;
      unlocked             <= 1'b0;
    end else if (wr) begin
      if (dir_hit)  pin_direction_reg    <= wbyte;
      if (sns_hit)  irq_sense_select     <= wbyte;
      if (dual_hit) irq_dual_edge_select <= wbyte;
      if (pol_hit)  irq_polarity_select  <= wbyte;
      if (msk_hit)  irq_mask_bits        <= wbyte;
      if (od_hit)   open_drain_enable    <= wbyte;
      if (pd_hit)   pull_down_enable     <= wbyte;
      if (slr_hit)  slew_select          <= wbyte;
      if (lock_hit) unlocked <= wdata == `GPC_UNLOCK_KEY;
    end
  end

  // pads and alt select, debug pins differ
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alt_function_select  <= dbg_mask;
      pull_up_enable       <= dbg_mask;
      digital_input_enable <= dbg_mask;
      commit_permit_bits   <= `GPC_RST_COMMIT & ~dbg_mask;
      drive_low_select     <= `GPC_RST_DRV2;
      drive_mid_select     <= `GPC_RST_ZERO;
      drive_high_select    <= `GPC_RST_ZERO;
    end else begin
      if (wr && alt_hit) alt_function_select <= next_alt;
      if (wr && pu_hit)  pull_up_enable      <= wbyte;
      if (wr && den_hit) digital_input_enable <= wbyte;
      if (wr && cr_hit && unlocked)
        commit_permit_bits <= (wbyte & dbg_mask) | ~dbg_mask;
      drive_low_select  <= d2_hit ? (drive_low_select | drv_clear) :
                           (drive_low_select & ~drv_clear);
      drive_mid_select  <= d4_hit ? (drive_mid_select | drv_clear) :
                           (drive_mid_select & ~drv_clear);
      drive_high_select <= d8_hit ? (drive_high_select | drv_clear) :
                           (drive_high_select & ~drv_clear);
    end
  end

  // input sampling, edge latch, read data, converter trigger
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_sync   <= `GPC_RST_ZERO;
      pin_prev   <= `GPC_RST_ZERO;
      edge_latch <= `GPC_RST_ZERO;
      rdata      <= 32'h00000000;
      trig_prev  <= 1'b0;
      adc_trigger <= 1'b0;
    end else begin
      pin_sync   <= pad_in & digital_input_enable;
      pin_prev   <= pin_sync;
      edge_latch <= next_edge;
      rdata      <= next_rdata;
      trig_prev  <= trig_now;
      adc_trigger <= trig_now & ~trig_prev;
    end
  end

  // pin muxing: peripheral or software ownership
  wire gpc_bits_t sw_oe = pin_direction_reg &
                          ~(open_drain_enable & pin_value_reg);
  wire gpc_bits_t sw_out = pin_value_reg & ~open_drain_enable;
  wire gpc_bits_t hw_oe = alt_oe & ~(open_drain_enable & alt_out);
  wire gpc_bits_t hw_out = alt_out & ~open_drain_enable;
  assign pad_oe  = (alt_function_select & hw_oe) |
                   (~alt_function_select & sw_oe);
  assign pad_out = (alt_function_select & hw_out) |
                   (~alt_function_select & sw_out);
  assign alt_in     = pad_in & digital_input_enable & alt_function_select;
  assign pull_up    = pull_up_enable;
  assign pull_down  = pull_down_enable;
  assign drive_2ma  = drive_low_select;
  assign drive_4ma  = drive_mid_select;
  assign drive_8ma  = drive_high_select;
  assign slew_ctl   = slew_select & drive_high_select;
  assign open_drain = open_drain_enable;
  assign input_en   = digital_input_enable;
  assign irq        = |irq_masked_state;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  reset_defaults_a: assert property (
    $rose(rst_n) |-> alt_function_select == dbg_mask &&
      pull_up_enable == dbg_mask && digital_input_enable == dbg_mask &&
      pull_down_enable == 8'h00 && (pad_oe & ~dbg_mask) == 8'h00)
    else $error("pin defaults wrong after reset");

  input_capture_a: assert property (
    $past(rst_n) && $past(rst_n, 2) |->
      ((pin_value_reg ^ $past(pad_in & digital_input_enable, 2)) &
      ~$past(pin_direction_reg) & ~$past(pin_direction_reg, 2) &
      $past(digital_input_enable, 2)) == 8'h00)
    else $error("input bit did not follow pin");

  output_drive_a: assert property (
    ((~pad_oe | (pad_out ^ pin_value_reg)) & pin_direction_reg &
      ~alt_function_select & ~open_drain_enable) == 8'h00)
    else $error("output bit not driven");

  masked_write_a: assert property (
    wr && data_hit |=> ((pin_value_reg ^ $past(pin_value_reg)) &
      ~$past(addr_mask) & $past(pin_direction_reg)) == 8'h00)
    else $error("masked data bit changed");

  masked_read_a: assert property (
    rd && data_hit |=> (rdata[7:0] & ~$past(addr_mask)) == 8'h00 &&
      rdata[7:0] == $past(pin_value_reg & addr_mask))
    else $error("data read mask wrong");

  status_read_a: assert property (
    rd && addr == `GPC_OFF_MSTAT |=>
      rdata[7:0] == $past(irq_raw_state & irq_mask_bits))
    else $error("masked status read wrong");

  edge_hold_a: assert property (
    edge_latch[0] && !(wr && clr_hit && wdata[0]) |=> edge_latch[0])
    else $error("edge latch lost without clear");

  clear_one_a: assert property (
    wr && clr_hit && wdata[0] && !edge_hit[0] |=> !edge_latch[0])
    else $error("clear did not drop latch");

  level_sense_a: assert property (
    irq_sense_select[0] && irq_polarity_select[0] && pin_sync[0] &&
      irq_mask_bits[0] |-> irq)
    else $error("high level did not interrupt");

  trigger_pulse_a: assert property (
    adc_trigger |-> PORT_INDEX == `GPC_PORT_B ##1 !adc_trigger)
    else $error("trigger longer than one cycle");

  lock_guard_a: assert property (
    wr && alt_hit && !unlocked |=>
      ((alt_function_select ^ $past(alt_function_select)) &
        dbg_mask) == 8'h00)
    else $error("locked alt bit changed");

  drive_excl_a: assert property (
    ((drive_low_select & drive_mid_select) |
     (drive_mid_select & drive_high_select) |
     (drive_low_select & drive_high_select)) == 8'h00)
    else $error("drive selects overlap");

  ident_read_a: assert property (
    rd && addr == `GPC_OFF_ID_BASE |=> rdata == {24'h000000, ID_BYTE0})
    else $error("identification word wrong");

  edge_irq_c: cover property (
    irq_mask_bits[4] && !irq_sense_select[4] ##1 edge_latch[4] ##1 irq);
  masked_write_c: cover property (wr && data_hit && addr_mask == 8'h26);
  unlock_commit_c: cover property (
    wr && lock_hit && wdata == `GPC_UNLOCK_KEY ##1 wr && alt_hit);
  trigger_c: cover property (adc_trigger);

endmodule : gpc_port

/* File: gpc_pin_model.sv */
// pin and peripheral model for one port: pads, pulls, outside drivers
// assumes the bench changes the outside drivers just after a clock edge
`timescale 1ns/100ps
module gpc_pin_model
  import gpc_pkg::*;
(
  input  wire logic      clock,
  input  wire gpc_bits_t pad_out,
  input  wire gpc_bits_t pad_oe,
  input  wire gpc_bits_t pull_up,
  input  wire gpc_bits_t pull_down,
  input  wire gpc_bits_t ext_level,
  input  wire gpc_bits_t ext_drive,
  output gpc_bits_t      pad_in,
  output gpc_bits_t      alt_out,
  output gpc_bits_t      alt_oe
);
  gpc_bits_t wire_lvl;

  initial begin
    pad_in = 8'h00;
    alt_out = 8'h00;
  end

  // peripheral drives the low four pins only
  assign alt_oe = 8'h0F;

  // port first, then outside source, then pulls, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i])
        wire_lvl[i] = pad_out[i];
      else if (ext_drive[i])
        wire_lvl[i] = ext_level[i];
      else if (pull_up[i])
        wire_lvl[i] = 1'b1;
      else if (pull_down[i])
        wire_lvl[i] = 1'b0;
      else
        wire_lvl[i] = ~pad_in[i];
    end
  end

  always @(posedge clock) begin
    pad_in <= wire_lvl;
    alt_out <= alt_out + 8'h01;
  end
endmodule : gpc_pin_model

/* File: gpc_port_tb_top.sv */
// self-checking bench for one port built as port b
// assumes the pin model stands on the pad side
`include "gpc_consts.svh"
`timescale 1ns/100ps
module gpc_port_tb_top
  import gpc_pkg::*;
;
  logic                   clock;
  logic                   rst_n;
  logic                   wr;
  logic                   rd;
  logic [`GPC_ADDR_W-1:0] addr;
  gpc_word_t              wdata;
  gpc_word_t              rdata;
  gpc_bits_t              pad_in, pad_out, pad_oe, alt_out, alt_oe, alt_in;
  gpc_bits_t              pull_up, pull_down, drive_2ma, drive_4ma;
  gpc_bits_t              drive_8ma, slew_ctl, open_drain, input_en;
  gpc_bits_t              ext_level, ext_drive;
  logic                   irq, adc_trigger;
  int                     num_errors, compares, trig_cnt;
  logic [4:0]             mode_tab [5];

  gpc_port #(.PORT_INDEX(`GPC_PORT_B), .ID_BYTE0(8'h5C)) i_gpc_port (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
    .pull_up(pull_up), .pull_down(pull_down), .drive_2ma(drive_2ma),
    .drive_4ma(drive_4ma), .drive_8ma(drive_8ma), .slew_ctl(slew_ctl),
    .open_drain(open_drain), .input_en(input_en), .irq(irq),
    .adc_trigger(adc_trigger));

  gpc_pin_model i_gpc_pin_model (
    .clock(clock), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pull_up),
    .pull_down(pull_down), .ext_level(ext_level), .ext_drive(ext_drive),
    .pad_in(pad_in), .alt_out(alt_out), .alt_oe(alt_oe));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    if (adc_trigger === 1'b1)
      trig_cnt++;
  end

  task automatic check(string what, gpc_word_t seen, gpc_word_t exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(logic [11:0] a, gpc_word_t d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_chk(string what, logic [11:0] a, gpc_word_t exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask : rd_chk

  task automatic pins(gpc_bits_t lvl);
    @(posedge clock);
    ext_level <= lvl;
    repeat (4) @(posedge clock);
    #1;
  endtask : pins

  task automatic defaults();
    rd_chk("alt", `GPC_OFF_ALT, 32'h80);
    rd_chk("pullup", `GPC_OFF_PUP, 32'h80);
    rd_chk("din", `GPC_OFF_DIN, 32'h80);
    rd_chk("pulldn", `GPC_OFF_PDN, 32'h00);
    rd_chk("drv2", `GPC_OFF_DRV2, 32'hFF);
    rd_chk("commit", `GPC_OFF_COMMIT, 32'h7F);
    check("oe", 32'(pad_oe), 32'h00);
    check("alt_in7", 32'(alt_in[7]), 32'h1);
    check("pull din", 32'({pull_up, input_en}), 32'h8080);
    check("drv8", 32'(drive_8ma), 32'h00);
    $display("test defaults done");
  endtask : defaults

  task automatic conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    #(3000 * 100);
    num_errors++;
    conclude();
  end

  initial begin
    // sense, dual, polarity, raw after rise, raw after fall
    mode_tab = '{5'b00110, 5'b00001, 5'b01011, 5'b10110, 5'b10001};
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    ext_level = 8'h00;
    ext_drive = 8'h7F;
    num_errors = 0;
    compares = 0;
    trig_cnt = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    defaults();
    // masked data writes and reads
    wr_reg(`GPC_OFF_DIR, 32'hFF);
    wr_reg(12'h3FC, 32'hFF);
    wr_reg(12'h098, 32'hEB);
    check("pad_out", 32'(pad_out & 8'h7F), 32'h7B);
    check("pad_oe", 32'(pad_oe & 8'h7F), 32'h7F);
    rd_chk("data", 12'h0C4, 32'h31);
    rd_chk("data0", 12'h000, 32'h00);
    wr_reg(`GPC_OFF_DIR, 32'h00);
    wr_reg(`GPC_OFF_DIN, 32'hFF);
    pins(8'h25);
    rd_chk("data in", 12'h1FC, 32'h25);
    $display("test data done");
    // edge interrupt on the converter trigger pin
    wr_reg(`GPC_OFF_MASK, 32'h00);
    wr_reg(`GPC_OFF_SENSE, 32'h00);
    wr_reg(`GPC_OFF_DUAL, 32'h00);
    wr_reg(`GPC_OFF_POL, 32'h10);
    wr_reg(`GPC_OFF_CLEAR, 32'hFF);
    wr_reg(`GPC_OFF_MASK, 32'h10);
    pins(8'h35);
    check("irq", 32'(irq), 32'h1);
    rd_chk("raw", `GPC_OFF_RAW, 32'h10);
    rd_chk("mstat", `GPC_OFF_MSTAT, 32'h10);
    check("trig", 32'(trig_cnt), 32'h1);
    pins(8'h25);
    pins(8'h35);
    wr_reg(`GPC_OFF_CLEAR, 32'hEF);
    check("irq held", 32'(irq), 32'h1);
    check("trig once", 32'(trig_cnt), 32'h1);
    wr_reg(`GPC_OFF_CLEAR, 32'h10);
    check("irq clr", 32'(irq), 32'h0);
    rd_chk("raw clr", `GPC_OFF_RAW, 32'h00);
    $display("test edge irq done");
    // every trigger mode on pin zero, masked
    pins(8'h24);
    foreach (mode_tab[m]) begin
      wr_reg(`GPC_OFF_MASK, 32'h00);
      wr_reg(`GPC_OFF_SENSE, 32'(mode_tab[m][4]));
      wr_reg(`GPC_OFF_DUAL, 32'(mode_tab[m][3]));
      wr_reg(`GPC_OFF_POL, 32'(mode_tab[m][2]) | 32'h10);
      wr_reg(`GPC_OFF_CLEAR, 32'hFF);
      pins(8'h25);
      rd_chk("raw rise", `GPC_OFF_RAW, 32'(mode_tab[m][1]));
      wr_reg(`GPC_OFF_CLEAR, 32'hFF);
      pins(8'h24);
      rd_chk("raw fall", `GPC_OFF_RAW, 32'(mode_tab[m][0]));
      check("irq masked", 32'(irq), 32'h0);
    end
    wr_reg(`GPC_OFF_POL, 32'h11);
    pins(8'h25);
    wr_reg(`GPC_OFF_MASK, 32'h01);
    check("irq level", 32'(irq), 32'h1);
    wr_reg(`GPC_OFF_MASK, 32'h00);
    $display("test modes done");
    // lock and commit
    wr_reg(`GPC_OFF_ALT, 32'h01);
    rd_chk("alt locked", `GPC_OFF_ALT, 32'h81);
    wr_reg(`GPC_OFF_LOCK, `GPC_UNLOCK_KEY);
    rd_chk("lock", `GPC_OFF_LOCK, 32'h0);
    wr_reg(`GPC_OFF_COMMIT, 32'hFF);
    wr_reg(`GPC_OFF_ALT, 32'h01);
    rd_chk("alt open", `GPC_OFF_ALT, 32'h01);
    check("alt pin", 32'({pad_oe[0], pad_out[0]}),
          32'({alt_oe[0], alt_out[0]}));
    $display("test commit done");
    // pads and identification
    wr_reg(`GPC_OFF_DRV8, 32'h0F);
    rd_chk("drv2", `GPC_OFF_DRV2, 32'hF0);
    check("drv8", 32'(drive_8ma), 32'h0F);
    wr_reg(`GPC_OFF_DRV4, 32'h30);
    check("drv4 drv2", 32'({drive_4ma, drive_2ma}), 32'h30C0);
    wr_reg(`GPC_OFF_SLEW, 32'h03);
    check("slew", 32'(slew_ctl), 32'h03);
    wr_reg(`GPC_OFF_ODRAIN, 32'h40);
    check("odrain", 32'(open_drain), 32'h40);
    wr_reg(`GPC_OFF_PDN, 32'h22);
    check("pulldn", 32'(pull_down), 32'h22);
    rd_chk("ident", `GPC_OFF_ID_BASE, 32'h5C);
    rd_chk("unmapped", 12'h600, 32'h0);
    $display("test pads done");
    // reset in mid-run
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    defaults();
    conclude();
  end
endmodule : gpc_port_tb_top
